/* File: pkg/fsf_pkg.sv */
// Constants and types for the floating-point status flag logic
package fsf_pkg;
    // ==========================================
    // Status word field positions
    localparam int unsigned SW_WIDTH = 16;
    localparam int unsigned EXC_COUNT = 6;
    localparam int unsigned BIT_INVALID = 0;
    localparam int unsigned BIT_DENORMAL = 1;
    localparam int unsigned BIT_DIVZERO = 2;
    localparam int unsigned BIT_OVERFLOW = 3;
    localparam int unsigned BIT_UNDERFLOW = 4;
    localparam int unsigned BIT_INEXACT = 5;
    localparam int unsigned BIT_STACK_FAULT = 6;
    localparam int unsigned BIT_SUMMARY = 7;
    localparam int unsigned BIT_COND_ZERO = 8;
    localparam int unsigned BIT_COND_ONE = 9;
    localparam int unsigned BIT_COND_TWO = 10;
    localparam int unsigned BIT_COND_THREE = 14;
    localparam int unsigned BIT_BUSY_MIRROR = 15;

    // ==========================================
    // Reset and init values
    localparam logic [5:0] EXC_CLEAR = 6'h00;
    localparam logic [3:0] COND_CLEAR = 4'h0;
    localparam logic [5:0] MASK_INIT = 6'h3F;

    // ==========================================
    // Instruction classes presented to the block
    typedef enum logic [3:0] {
        FSF_OP_NONE = 4'h0,
        FSF_OP_COMPARE = 4'h1,
        FSF_OP_COMPARE_INT = 4'h2,
        FSF_OP_REMAINDER = 4'h3,
        FSF_OP_TRIG = 4'h4,
        FSF_OP_ARITH = 4'h5,
        FSF_OP_LOADMOVE = 4'h6,
        FSF_OP_EXAMINE = 4'h7,
        FSF_OP_CLEAR_EXC = 4'h8,
        FSF_OP_INIT = 4'h9,
        FSF_OP_SAVE = 4'hA,
        FSF_OP_RESTORE = 4'hB,
        FSF_OP_CONTROL = 4'hC
    } fsf_op_e;
endpackage : fsf_pkg

/* File: hw/fsf_summary.sv */
// Summary flag calculation from flags and masks
`timescale 1ns/1ps
module fsf_summary
    import fsf_pkg::*;
#(
    parameter int unsigned N = EXC_COUNT
) (
    // Flags and masks
    input wire logic [N-1:0] excFlags,
    input wire logic [N-1:0] excMasks,
    // Result
    output logic summary
);
    // ==========================================
    // Any unmasked flag raises the summary
    assign summary = |(excFlags & ~excMasks);
endmodule : fsf_summary

/* File: hw/fsf_status_flags.sv */
// Status-word flag and condition-code logic of a floating-point unit
// What this block does
// - Six sticky exception flags live in status bits 0 to 5.
// - Each exception flag has a control-word mask bit.
// - Summary bit 7 is set when any unmasked flag is set.
// - Masked exceptions set their flag but never raise summary.
// - A set summary flag requests the exception handler.
// - Exception flags stay set until an explicit clearing action.
// - Clear, init and save zero flags; only restore overwrites them from memory.
// - Bit 15 always mirrors the summary flag.
// - Compares put result in C0, C3, C2; C1 zero or stack fault.
// - Compare-to-integer-flags leaves C0, C2, C3; C1 only stack fault.
// - Remainder loads quotient bits into C0, C3, C1; C2 incomplete.
// - Trig sets C2 when out of range; C1 roundup or fault.
// - Restore takes condition bits straight from memory.
// - Stack fault flag lives in status bit 6.
// - Stack over/underflow sets stack fault; invalid operand never clears it.
// - With stack fault set by a compare to examine op, C1 is 1 for overflow, 0 for underflow; none and control ops keep C1.
// - Stack fault is sticky until init, clear or save, or until restore reloads it.
// - Stack fault exception shows as invalid flag and stack fault together.
`timescale 1ns/1ps
module fsf_status_flags
    import fsf_pkg::*;
#(
    parameter int unsigned N = EXC_COUNT
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Instruction completion
    input wire logic opValid,
    input wire logic [3:0] opClass,
    input wire logic [N-1:0] opExc,
    input wire logic opStackFault,
    input wire logic opStackOverflow,
    input wire logic [3:0] opCond,
    input wire logic [2:0] opQuotient,
    input wire logic opIncomplete,
    input wire logic opOutOfRange,
    input wire logic opRoundUp,
    // Memory image for load or restore
    input wire logic [SW_WIDTH-1:0] memStatus,
    // Control word masks
    input wire logic maskWrite,
    input wire logic [N-1:0] maskData,
    // Status view
    output logic [SW_WIDTH-1:0] statusWord,
    output logic handlerRequest,
    output logic [N-1:0] maskBits
);
    // ==========================================
    // State
    logic [N-1:0] excFlags_q;
    logic [N-1:0] excFlags_d;
    logic stackFault_q;
    logic stackFault_d;
    logic [3:0] cond_q;
    logic [3:0] cond_d;
    logic [N-1:0] mask_q;
    logic [N-1:0] mask_d;
    logic summaryNext;
    fsf_op_e op;

    assign op = fsf_op_e'(opClass);

    function automatic logic isClearOp(input fsf_op_e o);
        isClearOp = (o == FSF_OP_CLEAR_EXC) || (o == FSF_OP_INIT) || (o == FSF_OP_SAVE);
    endfunction : isClearOp

    function automatic logic isLoadOp(input fsf_op_e o);
        isLoadOp = (o == FSF_OP_RESTORE);
    endfunction : isLoadOp

    // ==========================================
    // Mask bits; init and save mask everything
    always_comb begin
        mask_d = mask_q;
        if (opValid && (op == FSF_OP_INIT || op == FSF_OP_SAVE)) begin
            mask_d = MASK_INIT;
        end else if (maskWrite) begin
            mask_d = maskData;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mask_q <= MASK_INIT;
        end else begin
            mask_q <= mask_d;
        end
    end

    // ==========================================
    // Sticky exception flags
    always_comb begin
        excFlags_d = excFlags_q;
        if (opValid && isClearOp(op)) begin
            excFlags_d = EXC_CLEAR;
        end else if (opValid && isLoadOp(op)) begin
            excFlags_d = memStatus[N-1:0];
        end else if (opValid) begin
            excFlags_d = excFlags_q | opExc;
            if (opStackFault) begin
                excFlags_d[BIT_INVALID] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            excFlags_q <= EXC_CLEAR;
        end else begin
            excFlags_q <= excFlags_d;
        end
    end

    // ==========================================
    // Stack fault flag; invalid operand alone leaves it untouched
    always_comb begin
        stackFault_d = stackFault_q;
        if (opValid && isClearOp(op)) begin
            stackFault_d = 1'b0;
        end else if (opValid && isLoadOp(op)) begin
            stackFault_d = memStatus[BIT_STACK_FAULT];
        end else if (opValid && opStackFault) begin
            stackFault_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            stackFault_q <= 1'b0;
        end else begin
            stackFault_q <= stackFault_d;
        end
    end

    // ==========================================
    // Condition codes, bit order {C3,C2,C1,C0}
    always_comb begin
        cond_d = cond_q;
        if (opValid) begin
            unique case (op)
                FSF_OP_COMPARE: begin
                    cond_d = {opCond[3], opCond[2], opStackFault & opStackOverflow, opCond[0]};
                end
                FSF_OP_COMPARE_INT: begin
                    // Undefined bits simply keep their old value
                    cond_d[1] = opStackFault & opStackOverflow;
                end
                FSF_OP_REMAINDER: begin
                    cond_d[0] = opQuotient[2];
                    cond_d[3] = opQuotient[1];
                    cond_d[1] = opStackFault ? opStackOverflow : opQuotient[0];
                    cond_d[2] = opIncomplete;
                end
                FSF_OP_TRIG: begin
                    cond_d[2] = opOutOfRange;
                    cond_d[1] = opStackFault ? opStackOverflow : (opRoundUp & ~opOutOfRange);
                end
                FSF_OP_ARITH: begin
                    cond_d[1] = opStackFault ? opStackOverflow : opRoundUp;
                end
                FSF_OP_LOADMOVE: begin
                    cond_d[1] = opStackFault & opStackOverflow;
                end
                FSF_OP_EXAMINE: begin
                    // Class code passes through, but a stack fault still owns C1
                    cond_d = {opCond[3], opCond[2], opStackFault ? opStackOverflow : opCond[1], opCond[0]};
                end
                FSF_OP_INIT, FSF_OP_SAVE: begin
                    cond_d = COND_CLEAR;
                end
                FSF_OP_RESTORE: begin
                    cond_d = {memStatus[BIT_COND_THREE], memStatus[BIT_COND_TWO],
                              memStatus[BIT_COND_ONE], memStatus[BIT_COND_ZERO]};
                end
                default: begin
                    cond_d = cond_q;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            cond_q <= COND_CLEAR;
        end else begin
            cond_q <= cond_d;
        end
    end

    // ==========================================
    // Summary from next flags and masks, so outputs stay registered
    fsf_summary #(.N(N)) uSummary (
        .excFlags(excFlags_d),
        .excMasks(mask_d),
        .summary(summaryNext)
    );

    always_ff @(posedge clk) begin
        if (reset) begin
            statusWord <= '0;
            handlerRequest <= 1'b0;
            maskBits <= MASK_INIT;
        end else begin
            statusWord <= '0;
            statusWord[N-1:0] <= excFlags_d;
            statusWord[BIT_STACK_FAULT] <= stackFault_d;
            statusWord[BIT_SUMMARY] <= summaryNext;
            statusWord[BIT_COND_ZERO] <= cond_d[0];
            statusWord[BIT_COND_ONE] <= cond_d[1];
            statusWord[BIT_COND_TWO] <= cond_d[2];
            statusWord[BIT_COND_THREE] <= cond_d[3];
            statusWord[BIT_BUSY_MIRROR] <= summaryNext;
            handlerRequest <= summaryNext;
            maskBits <= mask_d;
        end
    end

    // ==========================================
    // Checks
    // Outputs are registered, so every effect is checked one cycle after the op
    AST_MIRROR: assert property (@(posedge clk) disable iff (reset)
        statusWord[BIT_BUSY_MIRROR] == statusWord[BIT_SUMMARY])
        else $error("mirror bit differs from summary");

    AST_SUMMARY: assert property (@(posedge clk) disable iff (reset)
        statusWord[BIT_SUMMARY] == |(statusWord[N-1:0] & ~maskBits))
        else $error("summary does not match unmasked flags");

    AST_HANDLER: assert property (@(posedge clk) disable iff (reset)
        handlerRequest == statusWord[BIT_SUMMARY])
        else $error("handler request not tied to summary");

    AST_STICKY: assert property (@(posedge clk) disable iff (reset)
        opValid && !isClearOp(op) && !isLoadOp(op) |=> (statusWord[N-1:0] & $past(excFlags_q)) == $past(excFlags_q))
        else $error("sticky flag lost");

    AST_CLEAR: assert property (@(posedge clk) disable iff (reset)
        opValid && isClearOp(op) |=> statusWord[N-1:0] == EXC_CLEAR && !statusWord[BIT_STACK_FAULT])
        else $error("clear left a flag set");

    AST_SF_SET: assert property (@(posedge clk) disable iff (reset)
        opValid && opStackFault && !isClearOp(op) && !isLoadOp(op) |=>
        statusWord[BIT_STACK_FAULT] && statusWord[BIT_INVALID])
        else $error("stack fault not flagged");

    AST_SF_C1: assert property (@(posedge clk) disable iff (reset)
        opValid && opStackFault && op == FSF_OP_ARITH |=> statusWord[BIT_COND_ONE] == $past(opStackOverflow))
        else $error("C1 does not show fault kind");

    AST_REM: assert property (@(posedge clk) disable iff (reset)
        opValid && op == FSF_OP_REMAINDER && !opStackFault |=>
        {statusWord[BIT_COND_ZERO], statusWord[BIT_COND_THREE], statusWord[BIT_COND_ONE]} == $past(opQuotient)
        && statusWord[BIT_COND_TWO] == $past(opIncomplete))
        else $error("remainder condition bits wrong");

    AST_TRIG: assert property (@(posedge clk) disable iff (reset)
        opValid && op == FSF_OP_TRIG |=> statusWord[BIT_COND_TWO] == $past(opOutOfRange))
        else $error("range bit wrong");

    AST_FLAG_SET: assert property (@(posedge clk) disable iff (reset)
        opValid && !isClearOp(op) && !isLoadOp(op) |=> (statusWord[N-1:0] & $past(opExc)) == $past(opExc))
        else $error("exception event did not set its flag");

    AST_MASK_LOAD: assert property (@(posedge clk) disable iff (reset)
        maskWrite && !(opValid && (op == FSF_OP_INIT || op == FSF_OP_SAVE)) |=> maskBits == $past(maskData))
        else $error("mask write not taken");

    AST_INIT: assert property (@(posedge clk) disable iff (reset)
        opValid && (op == FSF_OP_INIT || op == FSF_OP_SAVE) |=> maskBits == MASK_INIT
        && !statusWord[BIT_COND_ZERO] && !statusWord[BIT_COND_ONE]
        && !statusWord[BIT_COND_TWO] && !statusWord[BIT_COND_THREE])
        else $error("init or save left masks or condition bits");

    AST_RESTORE_FLAGS: assert property (@(posedge clk) disable iff (reset)
        opValid && isLoadOp(op) |=> statusWord[N-1:0] == $past(memStatus[N-1:0])
        && statusWord[BIT_STACK_FAULT] == $past(memStatus[BIT_STACK_FAULT]))
        else $error("restore did not load flags");

    AST_RESTORE_COND: assert property (@(posedge clk) disable iff (reset)
        opValid && isLoadOp(op) |=>
        statusWord[BIT_COND_ZERO] == $past(memStatus[BIT_COND_ZERO])
        && statusWord[BIT_COND_ONE] == $past(memStatus[BIT_COND_ONE])
        && statusWord[BIT_COND_TWO] == $past(memStatus[BIT_COND_TWO])
        && statusWord[BIT_COND_THREE] == $past(memStatus[BIT_COND_THREE]))
        else $error("restore did not load condition bits");

    AST_COMPARE: assert property (@(posedge clk) disable iff (reset)
        opValid && op == FSF_OP_COMPARE |=>
        statusWord[BIT_COND_ZERO] == $past(opCond[0]) && statusWord[BIT_COND_TWO] == $past(opCond[2])
        && statusWord[BIT_COND_THREE] == $past(opCond[3]))
        else $error("compare result bits wrong");

    AST_COMPARE_C1: assert property (@(posedge clk) disable iff (reset)
        opValid && (op == FSF_OP_COMPARE || op == FSF_OP_COMPARE_INT) && !opStackFault |=>
        !statusWord[BIT_COND_ONE])
        else $error("compare C1 set without a fault");

    AST_FAULT_KIND: assert property (@(posedge clk) disable iff (reset)
        opValid && opStackFault && op inside {[FSF_OP_COMPARE:FSF_OP_EXAMINE]} |=>
        statusWord[BIT_COND_ONE] == $past(opStackOverflow))
        else $error("C1 does not show overflow or underflow");

    AST_TRIG_C1: assert property (@(posedge clk) disable iff (reset)
        opValid && op == FSF_OP_TRIG && opOutOfRange && !opStackFault |=> !statusWord[BIT_COND_ONE])
        else $error("C1 set for out of range source");

    AST_SF_STICKY: assert property (@(posedge clk) disable iff (reset)
        statusWord[BIT_STACK_FAULT] && !(opValid && (isClearOp(op) || isLoadOp(op))) |=>
        statusWord[BIT_STACK_FAULT])
        else $error("stack fault flag lost");

    AST_IDLE_HOLD: assert property (@(posedge clk) disable iff (reset)
        !opValid && !maskWrite |=> $stable(statusWord))
        else $error("status changed with no op");
endmodule : fsf_status_flags

/* File: test/fsf_status_flags_tb.sv */
// Self-checking bench for the status-flag logic
`timescale 1ns/1ps
module fsf_status_flags_tb import fsf_pkg::*;;
    // ==========================================
    // Signals
    logic clk, reset, opValid, opStackFault, opStackOverflow, opIncomplete;
    logic opOutOfRange, opRoundUp, maskWrite, handlerRequest, mSf, c1Known, c1;
    logic live = 1'b0;
    logic [3:0] opClass, opCond, mCond;
    logic [5:0] opExc, maskData, maskBits, mFlags, mMasks;
    logic [2:0] opQuotient;
    logic [15:0] memStatus, statusWord;
    int errorCnt = 0;
    int numChecks = 0;
    int cycles = 0;

    fsf_status_flags dut (
        .clk(clk), .reset(reset), .opValid(opValid), .opClass(opClass), .opExc(opExc),
        .opStackFault(opStackFault), .opStackOverflow(opStackOverflow), .opCond(opCond),
        .opQuotient(opQuotient), .opIncomplete(opIncomplete), .opOutOfRange(opOutOfRange),
        .opRoundUp(opRoundUp), .memStatus(memStatus), .maskWrite(maskWrite),
        .maskData(maskData), .statusWord(statusWord), .handlerRequest(handlerRequest),
        .maskBits(maskBits)
    );

    // ==========================================
    // Expectations and compares
    function automatic logic [15:0] expStatus();
        logic s;
        s = |(mFlags & ~mMasks);
        return {s, mCond[3], 3'h0, mCond[2:0], s, mSf, mFlags};
    endfunction : expStatus

    task automatic miss(input logic [15:0] got, input logic [15:0] exp);
        errorCnt++;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    endtask : miss

    task automatic checkWord(input logic [15:0] got, input logic [15:0] exp, input logic [15:0] k);
        numChecks++;
        if ((got & k) !== (exp & k)) miss(got, exp);
    endtask : checkWord

    task automatic checkBit(input logic got, input logic exp);
        numChecks++;
        if (got !== exp) miss(16'(got), 16'(exp));
    endtask : checkBit

    task automatic checkMask(input logic [5:0] got, input logic [5:0] exp);
        numChecks++;
        if (got !== exp) miss(16'(got), 16'(exp));
    endtask : checkMask

    task automatic reportAndStop();
        $display("checks %0d errors %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : reportAndStop

    // ==========================================
    // Watchdog and reference model, one op per edge
    always @(posedge clk) begin
        cycles++;
        if (cycles > 4000) begin
            errorCnt++;
            reportAndStop();
        end
    end

    always @(posedge clk) begin
        if (live) begin
            checkWord(statusWord, expStatus(), c1Known ? 16'hFFFF : 16'hFDFF);
            checkBit(handlerRequest, |(mFlags & ~mMasks));
            checkMask(maskBits, mMasks);
        end
        if (reset) begin
            {mFlags, mSf, mCond, c1Known, mMasks} = {6'h00, 1'b0, 4'h0, 1'b1, 6'h3F};
        end else begin
            if (maskWrite) mMasks = maskData;
            if (opValid) begin
                c1 = opStackFault ? opStackOverflow : 1'b0;
                if (opClass != 4'h0 && opClass != 4'hC) c1Known = 1'b1;
                case (opClass)
                    4'h8: {mFlags, mSf} = 7'h00;
                    4'h9, 4'hA: {mFlags, mSf, mCond, mMasks} = {6'h00, 1'b0, 4'h0, 6'h3F};
                    4'hB: {mSf, mFlags, mCond} = {memStatus[6:0], memStatus[14], memStatus[10:8]};
                    default: begin
                        mFlags = mFlags | opExc;
                        if (opStackFault) {mSf, mFlags[0]} = 2'h3;
                        case (opClass)
                            4'h1: mCond = {opCond[3:2], c1, opCond[0]};
                            4'h2: {mCond[1], c1Known} = {c1, opStackFault};
                            4'h3: mCond = {opQuotient[1], opIncomplete, opStackFault ? c1 : opQuotient[0], opQuotient[2]};
                            4'h4: mCond[2:1] = {opOutOfRange, opStackFault ? c1 : opRoundUp & ~opOutOfRange};
                            4'h5: mCond[1] = opStackFault ? c1 : opRoundUp;
                            4'h6: mCond[1] = c1;
                            4'h7: mCond = {opCond[3:2], opStackFault ? c1 : opCond[1], opCond[0]};
                            default: ;
                        endcase
                    end
                endcase
            end
        end
        live = !reset;
    end

    // ==========================================
    // Stimulus; class F means no op taken
    task automatic drive(input logic [3:0] cls, input logic [5:0] exc, input logic sf, input logic ovf,
                         input logic mw, input logic [5:0] md);
        @(posedge clk);
        opValid <= (cls != 4'hF);
        opClass <= cls;
        opExc <= exc;
        opStackFault <= sf;
        opStackOverflow <= ovf;
        maskWrite <= mw;
        maskData <= md;
        {opCond, opQuotient, opIncomplete, opOutOfRange, opRoundUp} <= 10'($urandom);
        memStatus <= 16'($urandom);
    endtask : drive

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    initial begin
        logic [3:0] k;
        {reset, opValid, opClass, opExc, opStackFault, opStackOverflow, maskWrite, maskData} = {1'b1, 21'h0};
        {opCond, opQuotient, opIncomplete, opOutOfRange, opRoundUp, memStatus} = 26'h0;
        void'($urandom(3246));
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        drive(4'h9, 6'h00, 1'b0, 1'b0, 1'b1, 6'h00);
        drive(4'h5, 6'h01, 1'b1, 1'b1, 1'b0, 6'h00);
        drive(4'h0, 6'h00, 1'b0, 1'b0, 1'b1, 6'h3E);
        drive(4'h6, 6'h00, 1'b0, 1'b0, 1'b0, 6'h00);
        drive(4'h0, 6'h00, 1'b0, 1'b0, 1'b1, 6'h3F);
        drive(4'h8, 6'h3F, 1'b0, 1'b0, 1'b0, 6'h00);
        drive(4'h1, 6'h00, 1'b1, 1'b0, 1'b0, 6'h00);
        drive(4'hB, 6'h00, 1'b0, 1'b0, 1'b0, 6'h00);
        drive(4'hA, 6'h00, 1'b0, 1'b0, 1'b0, 6'h00);
        for (int i = 0; i < 3000; i++) begin
            k = 4'($urandom % 14);
            drive(k == 4'hD ? 4'hF : k, (k > 4'h8 && k < 4'hC) ? 6'h00 : 6'($urandom & $urandom),
                  k > 4'h0 && k < 4'h8 && $urandom % 6 == 0, 1'($urandom), $urandom % 4 == 0,
                  6'($urandom));
        end
        drive(4'hF, 6'h00, 1'b0, 1'b0, 1'b0, 6'h00);
        repeat (2) @(posedge clk);
        reportAndStop();
    end
endmodule : fsf_status_flags_tb
